/* core/osc_pll_config_regs.vh */
// Register offsets, field positions and reset values of the oscillator and PLL configuration block
`ifndef OSC_PLL_CONFIG_REGS_VH
`define OSC_PLL_CONFIG_REGS_VH

// Bus geometry
`define OPC_ADDR_W 8
`define OPC_DATA_W 32
`define OPC_BE_W 4
`define OPC_BYTE_W 8

// Register byte offsets
`define OPC_OFS_RUN_CLOCK_CONFIG 8'h60
`define OPC_OFS_PLL_SETTING_TRANSLATION 8'h64
`define OPC_OFS_EXTENDED_CLOCK_CONFIG 8'h70

// run_clock_config field positions
`define RCC_MAIN_OSC_DISABLE 0
`define RCC_INTERNAL_OSC_DISABLE 1
`define RCC_OSC_SOURCE_LSB 4
`define RCC_OSC_SOURCE_MSB 5
`define RCC_CRYSTAL_FREQ_CODE_LSB 6
`define RCC_CRYSTAL_FREQ_CODE_MSB 9
`define RCC_BYPASS 11
`define RCC_FIXED_ONE 12
`define RCC_PLL_POWER_DOWN 13
`define RCC_USE_SYS_DIV 22
`define RCC_SYS_DIV_LSB 23
`define RCC_SYS_DIV_MSB 26
`define RCC_AUTO_CLOCK_GATE 27

// run_clock_config reset values
`define RCC_RST_MAIN_OSC_DISABLE 1'b1
`define RCC_RST_INTERNAL_OSC_DISABLE 1'b0
`define RCC_RST_OSC_SOURCE 2'h1
`define RCC_RST_CRYSTAL_FREQ_CODE 4'hB
`define RCC_RST_BYPASS 1'b1
`define RCC_FIXED_ONE_VAL 1'b1
`define RCC_RST_PLL_POWER_DOWN 1'b1
`define RCC_RST_USE_SYS_DIV 1'b0
`define RCC_RST_SYS_DIV 4'hF
`define RCC_RST_AUTO_CLOCK_GATE 1'b0

// extended_clock_config field positions
`define ECC_OSC_SOURCE_LSB 4
`define ECC_OSC_SOURCE_MSB 6
`define ECC_BYPASS 11
`define ECC_PLL_POWER_DOWN 13
`define ECC_SYS_DIV_LSB 23
`define ECC_SYS_DIV_MSB 28
`define ECC_USE_EXTENDED_CONFIG 31

// extended_clock_config reset values
`define ECC_RST_OSC_SOURCE 3'h1
`define ECC_RST_BYPASS 1'b1
`define ECC_RST_PLL_POWER_DOWN 1'b1
`define ECC_RST_SYS_DIV 6'h0F
`define ECC_RST_USE_EXTENDED_CONFIG 1'b0

// pll_setting_translation field positions and widths
`define PST_DIV_LSB 0
`define PST_DIV_MSB 4
`define PST_MULT_LSB 5
`define PST_MULT_MSB 13
`define PST_MULT_W 9
`define PST_DIV_W 5

// Translation for the reset crystal code
`define PST_RST_MULT 9'h0C8
`define PST_RST_DIV 5'h02

`endif

/* core/pll_xlate_rom.v */
// Crystal code to PLL multiplier and divider lookup with registered output
`timescale 1ns/1ps
`include "osc_pll_config_regs.vh"

module pll_xlate_rom
(
	// Clock and reset
	input wire i_core_clk,
	input wire i_resetn,
	// Lookup
	input wire [3:0] i_crystal_freq_code,
	output reg [`PST_MULT_W-1:0] o_mult,
	output reg [`PST_DIV_W-1:0] o_div
);

	reg [`PST_MULT_W-1:0] mult_d;
	reg [`PST_DIV_W-1:0] div_d;

	// Entries aim at a 400 MHz PLL output; codes 0x0 to 0x3 give zero
	always @*
	begin
		mult_d = 9'h000;
		div_d = 5'h00;
		case (i_crystal_freq_code)
			4'h4:
			begin
				mult_d = 9'h1BF;
				div_d = 5'h03;
			end
			4'h5:
			begin
				mult_d = 9'h0D9;
				div_d = 5'h01;
			end
			4'h6:
			begin
				mult_d = 9'h064;
				div_d = 5'h00;
			end
			4'h7:
			begin
				mult_d = 9'h125;
				div_d = 5'h02;
			end
			4'h8:
			begin
				mult_d = 9'h197;
				div_d = 5'h04;
			end
			4'h9:
			begin
				mult_d = 9'h050;
				div_d = 5'h00;
			end
			4'hA:
			begin
				mult_d = 9'h139;
				div_d = 5'h03;
			end
			4'hB:
			begin
				mult_d = `PST_RST_MULT;
				div_d = `PST_RST_DIV;
			end
			4'hC:
			begin
				mult_d = 9'h187;
				div_d = 5'h05;
			end
			4'hD:
			begin
				mult_d = 9'h0D9;
				div_d = 5'h03;
			end
			4'hE:
			begin
				mult_d = 9'h032;
				div_d = 5'h00;
			end
			4'hF:
			begin
				mult_d = 9'h125;
				div_d = 5'h05;
			end
			default:
			begin
				mult_d = 9'h000;
				div_d = 5'h00;
			end
		endcase
	end

	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_mult <= `PST_RST_MULT;
			o_div <= `PST_RST_DIV;
		end
		else
		begin
			o_mult <= mult_d;
			o_div <= div_d;
		end
	end

endmodule // pll_xlate_rom

/* core/osc_pll_config.v */
// Oscillator and PLL run-mode configuration registers with Avalon-MM slave
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`include "osc_pll_config_regs.vh"

// Contract
// - PLL power-down output follows bit 13, resets set
// - Bypass bit 11 selects oscillator over PLL
// - Crystal code in bits 9:6, resets 0xB
// - Bits 5:4 select oscillator source, reset internal
// - Bit 1 set stops internal oscillator
// - Bit 0 set disables main oscillator, reset set
// - Reserved bits read-only; bit 12 reads one
// - Translation loaded at reset, follows crystal code
// - PLL frequency is osc times mult over div+1
// - Multiplier bits 13:5, divider bits 4:0, rest zero
// - Extended use bit overrides divider, power, bypass, source
module osc_pll_config
(
	// Clock and reset
	input wire i_core_clk,
	input wire i_resetn,
	// Avalon-MM slave
	input wire [`OPC_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [`OPC_DATA_W-1:0] i_avs_writedata,
	input wire [`OPC_BE_W-1:0] i_avs_byteenable,
	output reg [`OPC_DATA_W-1:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	// Oscillator controls
	output reg o_main_osc_disable,
	output reg o_internal_osc_disable,
	output reg [2:0] o_osc_source,
	// PLL controls
	output reg o_pll_power_down,
	output reg o_pll_bypass,
	output reg [`PST_MULT_W-1:0] o_pll_mult,
	output reg [`PST_DIV_W-1:0] o_pll_div,
	// System clock divider controls
	output reg [5:0] o_sys_div,
	output reg o_use_sys_div,
	output reg o_auto_clock_gate
);

	// run_clock_config fields
	reg main_osc_disable_q;
	reg internal_osc_disable_q;
	reg [1:0] osc_source_q;
	reg [3:0] crystal_freq_code_q;
	reg bypass_q;
	reg pll_power_down_q;
	reg use_sys_div_q;
	reg [3:0] sys_div_q;
	reg auto_clock_gate_q;

	// extended_clock_config fields
	reg use_extended_config_q;
	reg [5:0] ext_sys_div_q;
	reg ext_pll_power_down_q;
	reg ext_bypass_q;
	reg [2:0] ext_osc_source_q;

	// Bus handshake
	reg ack_q;
	wire ack_d;
	wire commit_write;
	wire sel_rcc;
	wire sel_pst;
	wire sel_ecc;

	// Translation lookup
	wire [`PST_MULT_W-1:0] xlate_mult;
	wire [`PST_DIV_W-1:0] xlate_div;

	// Readback images
	reg [`OPC_DATA_W-1:0] rcc_image;
	reg [`OPC_DATA_W-1:0] ecc_image;
	reg [`OPC_DATA_W-1:0] pst_image;
	reg [`OPC_DATA_W-1:0] read_mux;
	reg [`OPC_DATA_W-1:0] old_word;
	reg [`OPC_DATA_W-1:0] wdata_m;

	// Effective controls
	reg pll_power_down_d;
	reg bypass_d;
	reg [2:0] osc_source_d;
	reg [5:0] sys_div_d;

	assign sel_rcc = (i_avs_address == `OPC_OFS_RUN_CLOCK_CONFIG);
	assign sel_pst = (i_avs_address == `OPC_OFS_PLL_SETTING_TRANSLATION);
	assign sel_ecc = (i_avs_address == `OPC_OFS_EXTENDED_CLOCK_CONFIG);

	// Waitrequest drops for one cycle, one cycle after the request appears
	assign ack_d = (i_avs_read | i_avs_write) & ~ack_q;
	assign commit_write = i_avs_write & ack_q;

	// Translation lookup table
	pll_xlate_rom u_xlate
	(
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_crystal_freq_code(crystal_freq_code_q),
		.o_mult(xlate_mult),
		.o_div(xlate_div)
	);

	// Readback of run_clock_config; unlisted bits read zero
	always @*
	begin
		rcc_image = {`OPC_DATA_W{1'b0}};
		rcc_image[`RCC_MAIN_OSC_DISABLE] = main_osc_disable_q;
		rcc_image[`RCC_INTERNAL_OSC_DISABLE] = internal_osc_disable_q;
		rcc_image[`RCC_OSC_SOURCE_MSB:`RCC_OSC_SOURCE_LSB] = osc_source_q;
		rcc_image[`RCC_CRYSTAL_FREQ_CODE_MSB:`RCC_CRYSTAL_FREQ_CODE_LSB] = crystal_freq_code_q;
		rcc_image[`RCC_BYPASS] = bypass_q;
		rcc_image[`RCC_FIXED_ONE] = `RCC_FIXED_ONE_VAL;
		rcc_image[`RCC_PLL_POWER_DOWN] = pll_power_down_q;
		rcc_image[`RCC_USE_SYS_DIV] = use_sys_div_q;
		rcc_image[`RCC_SYS_DIV_MSB:`RCC_SYS_DIV_LSB] = sys_div_q;
		rcc_image[`RCC_AUTO_CLOCK_GATE] = auto_clock_gate_q;
	end

	// Readback of extended_clock_config
	always @*
	begin
		ecc_image = {`OPC_DATA_W{1'b0}};
		ecc_image[`ECC_OSC_SOURCE_MSB:`ECC_OSC_SOURCE_LSB] = ext_osc_source_q;
		ecc_image[`ECC_BYPASS] = ext_bypass_q;
		ecc_image[`ECC_PLL_POWER_DOWN] = ext_pll_power_down_q;
		ecc_image[`ECC_SYS_DIV_MSB:`ECC_SYS_DIV_LSB] = ext_sys_div_q;
		ecc_image[`ECC_USE_EXTENDED_CONFIG] = use_extended_config_q;
	end

	// Readback of pll_setting_translation
	always @*
	begin
		pst_image = {`OPC_DATA_W{1'b0}};
		pst_image[`PST_MULT_MSB:`PST_MULT_LSB] = xlate_mult;
		pst_image[`PST_DIV_MSB:`PST_DIV_LSB] = xlate_div;
	end

	// Read select; unmapped offsets read zero
	always @*
	begin
		read_mux = {`OPC_DATA_W{1'b0}};
		old_word = {`OPC_DATA_W{1'b0}};
		if (sel_rcc)
		begin
			read_mux = rcc_image;
			old_word = rcc_image;
		end
		else if (sel_ecc)
		begin
			read_mux = ecc_image;
			old_word = ecc_image;
		end
		else if (sel_pst)
		begin
			read_mux = pst_image;
		end
	end

	// Byte enables merge write data over the current word
	always @*
	begin
		wdata_m = old_word;
		if (i_avs_byteenable[0])
		begin
			wdata_m[0 +: `OPC_BYTE_W] = i_avs_writedata[0 +: `OPC_BYTE_W];
		end
		if (i_avs_byteenable[1])
		begin
			wdata_m[`OPC_BYTE_W +: `OPC_BYTE_W] = i_avs_writedata[`OPC_BYTE_W +: `OPC_BYTE_W];
		end
		if (i_avs_byteenable[2])
		begin
			wdata_m[2*`OPC_BYTE_W +: `OPC_BYTE_W] = i_avs_writedata[2*`OPC_BYTE_W +: `OPC_BYTE_W];
		end
		if (i_avs_byteenable[3])
		begin
			wdata_m[3*`OPC_BYTE_W +: `OPC_BYTE_W] = i_avs_writedata[3*`OPC_BYTE_W +: `OPC_BYTE_W];
		end
	end

	// Bus handshake
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ack_q <= 1'b0;
			o_avs_waitrequest <= 1'b1;
		end
		else
		begin
			ack_q <= ack_d;
			o_avs_waitrequest <= ~ack_d;
		end
	end

	// Read data, loaded in the cycle that waitrequest drops
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_avs_readdata <= {`OPC_DATA_W{1'b0}};
		end
		else if (ack_d && i_avs_read)
		begin
			o_avs_readdata <= read_mux;
		end
	end

	// run_clock_config writable fields; reserved bits are never stored
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			main_osc_disable_q <= `RCC_RST_MAIN_OSC_DISABLE;
			internal_osc_disable_q <= `RCC_RST_INTERNAL_OSC_DISABLE;
			osc_source_q <= `RCC_RST_OSC_SOURCE;
			crystal_freq_code_q <= `RCC_RST_CRYSTAL_FREQ_CODE;
			bypass_q <= `RCC_RST_BYPASS;
			pll_power_down_q <= `RCC_RST_PLL_POWER_DOWN;
			use_sys_div_q <= `RCC_RST_USE_SYS_DIV;
			sys_div_q <= `RCC_RST_SYS_DIV;
			auto_clock_gate_q <= `RCC_RST_AUTO_CLOCK_GATE;
		end
		else if (commit_write && sel_rcc)
		begin
			main_osc_disable_q <= wdata_m[`RCC_MAIN_OSC_DISABLE];
			internal_osc_disable_q <= wdata_m[`RCC_INTERNAL_OSC_DISABLE];
			osc_source_q <= wdata_m[`RCC_OSC_SOURCE_MSB:`RCC_OSC_SOURCE_LSB];
			crystal_freq_code_q <= wdata_m[`RCC_CRYSTAL_FREQ_CODE_MSB:`RCC_CRYSTAL_FREQ_CODE_LSB];
			bypass_q <= wdata_m[`RCC_BYPASS];
			pll_power_down_q <= wdata_m[`RCC_PLL_POWER_DOWN];
			use_sys_div_q <= wdata_m[`RCC_USE_SYS_DIV];
			sys_div_q <= wdata_m[`RCC_SYS_DIV_MSB:`RCC_SYS_DIV_LSB];
			auto_clock_gate_q <= wdata_m[`RCC_AUTO_CLOCK_GATE];
		end
	end

	// extended_clock_config writable fields
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			use_extended_config_q <= `ECC_RST_USE_EXTENDED_CONFIG;
			ext_sys_div_q <= `ECC_RST_SYS_DIV;
			ext_pll_power_down_q <= `ECC_RST_PLL_POWER_DOWN;
			ext_bypass_q <= `ECC_RST_BYPASS;
			ext_osc_source_q <= `ECC_RST_OSC_SOURCE;
		end
		else if (commit_write && sel_ecc)
		begin
			use_extended_config_q <= wdata_m[`ECC_USE_EXTENDED_CONFIG];
			ext_sys_div_q <= wdata_m[`ECC_SYS_DIV_MSB:`ECC_SYS_DIV_LSB];
			ext_pll_power_down_q <= wdata_m[`ECC_PLL_POWER_DOWN];
			ext_bypass_q <= wdata_m[`ECC_BYPASS];
			ext_osc_source_q <= wdata_m[`ECC_OSC_SOURCE_MSB:`ECC_OSC_SOURCE_LSB];
		end
	end

	// Effective settings, with the extended register taking over when enabled
	always @*
	begin
		if (use_extended_config_q)
		begin
			pll_power_down_d = ext_pll_power_down_q;
			bypass_d = ext_bypass_q;
			osc_source_d = ext_osc_source_q;
			sys_div_d = ext_sys_div_q;
		end
		else
		begin
			pll_power_down_d = pll_power_down_q;
			bypass_d = bypass_q;
			osc_source_d = {1'b0, osc_source_q};
			sys_div_d = {2'b00, sys_div_q};
		end
	end

	// Registered oscillator controls
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_main_osc_disable <= `RCC_RST_MAIN_OSC_DISABLE;
			o_internal_osc_disable <= `RCC_RST_INTERNAL_OSC_DISABLE;
			o_osc_source <= {1'b0, `RCC_RST_OSC_SOURCE};
		end
		else
		begin
			o_main_osc_disable <= main_osc_disable_q;
			o_internal_osc_disable <= internal_osc_disable_q;
			o_osc_source <= osc_source_d;
		end
	end

	// Registered PLL controls
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_pll_power_down <= `RCC_RST_PLL_POWER_DOWN;
			o_pll_bypass <= `RCC_RST_BYPASS;
			o_pll_mult <= `PST_RST_MULT;
			o_pll_div <= `PST_RST_DIV;
		end
		else
		begin
			o_pll_power_down <= pll_power_down_d;
			o_pll_bypass <= bypass_d;
			o_pll_mult <= xlate_mult;
			o_pll_div <= xlate_div;
		end
	end

	// Registered system divider controls
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_sys_div <= {2'b00, `RCC_RST_SYS_DIV};
			o_use_sys_div <= `RCC_RST_USE_SYS_DIV;
			o_auto_clock_gate <= `RCC_RST_AUTO_CLOCK_GATE;
		end
		else
		begin
			o_sys_div <= sys_div_d;
			// Divider is forced in whenever the PLL is the source
			o_use_sys_div <= use_sys_div_q | ~bypass_d;
			o_auto_clock_gate <= auto_clock_gate_q;
		end
	end

endmodule // osc_pll_config

/* tb/osc_pll_config_asserts.sv */
// Concurrent checks on the ports of the oscillator and PLL configuration block
`timescale 1ns/1ps
module osc_pll_config_asserts
(
	// Clock and reset
	input wire i_core_clk,
	input wire i_resetn,
	// Register bus
	input wire [7:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	// Clock controls
	input wire o_main_osc_disable,
	input wire o_internal_osc_disable,
	input wire [2:0] o_osc_source,
	input wire o_pll_power_down,
	input wire o_pll_bypass,
	input wire [8:0] o_pll_mult,
	input wire [4:0] o_pll_div,
	input wire [5:0] o_sys_div,
	input wire o_use_sys_div,
	input wire o_auto_clock_gate
);
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_resetn);
reg ext_q;
wire acc = !o_avs_waitrequest && (i_avs_read || i_avs_write);
wire wr_rcc = acc && i_avs_write && i_avs_address == 8'h60;
wire [31:0] wd = i_avs_writedata;
wire [3:0] be = i_avs_byteenable;
// Extended override state seen from the bus
always @(posedge i_core_clk or negedge i_resetn)
	if (!i_resetn)
		ext_q <= 1'b0;
	else if (acc && i_avs_write && i_avs_address == 8'h70 && be[3])
		ext_q <= wd[31];
sequence s_req_idle;
	(i_avs_read || i_avs_write) && o_avs_waitrequest;
endsequence
sequence s_answer;
	!o_avs_waitrequest ##1 o_avs_waitrequest;
endsequence
a_wait_answer: assert property (s_req_idle |=> s_answer)
	else $error("bus answer not a single cycle");
a_pll_power: assert property (wr_rcc && be[1] && !ext_q |-> ##2 o_pll_power_down == $past(wd[13], 2))
	else $error("power down output wrong");
a_pll_bypass: assert property (wr_rcc && be[1] && !ext_q |-> ##2 o_pll_bypass == $past(wd[11], 2))
	else $error("bypass output wrong");
a_osc_source: assert property (wr_rcc && be[0] && !ext_q |-> ##2 o_osc_source == {1'b0, $past(wd[5:4], 2)})
	else $error("source output wrong");
a_osc_disable: assert property (wr_rcc && be[0] |-> ##2 {o_internal_osc_disable, o_main_osc_disable} == $past(wd[1:0], 2))
	else $error("oscillator disable outputs wrong");
a_unusable_crystal_freq_code: assert property (wr_rcc && be[1:0] == 2'h3 && wd[9:8] == 2'h0 |-> ##3 o_pll_mult == 9'h0 && o_pll_div == 5'h0)
	else $error("unusable code gives nonzero settings");
a_xlate_cause: assert property ($changed({o_pll_mult, o_pll_div}) |-> $past(wr_rcc, 3))
	else $error("translation changed without a write");
a_xlate_upper: assert property (acc && i_avs_read && i_avs_address == 8'h64 |-> o_avs_readdata[31:14] == 18'h0)
	else $error("translation upper bits not zero");
a_rcc_reserved: assert property (acc && i_avs_read && i_avs_address == 8'h60 |-> o_avs_readdata[21:14] == 8'h0 && o_avs_readdata[12] && !o_avs_readdata[10] && o_avs_readdata[3:2] == 2'h0)
	else $error("reserved bits read wrong");
a_ext_override: assert property (acc && i_avs_write && i_avs_address == 8'h70 && be == 4'hF && wd[31] |-> ##2 {o_pll_power_down, o_pll_bypass, o_osc_source} == {$past(wd[13], 2), $past(wd[11], 2), $past(wd[6:4], 2)})
	else $error("override not applied");
endmodule // osc_pll_config_asserts
bind osc_pll_config osc_pll_config_asserts i_osc_pll_config_asserts (.i_core_clk(i_core_clk),
	.i_resetn(i_resetn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_main_osc_disable(o_main_osc_disable),
	.o_internal_osc_disable(o_internal_osc_disable), .o_osc_source(o_osc_source),
	.o_pll_power_down(o_pll_power_down), .o_pll_bypass(o_pll_bypass), .o_pll_mult(o_pll_mult),
	.o_pll_div(o_pll_div), .o_sys_div(o_sys_div), .o_use_sys_div(o_use_sys_div),
	.o_auto_clock_gate(o_auto_clock_gate));

/* tb/osc_pll_config_test.sv */
// Self-checking testbench for the oscillator and PLL configuration block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module osc_pll_config_test;
reg i_core_clk = 1'b0;
reg i_resetn = 1'b0;
reg rd = 1'b0, wr = 1'b0;
reg [7:0] addr = 8'h00;
reg [31:0] wdata = 32'h0;
reg [3:0] be = 4'hF;
wire [31:0] rdata;
wire wait_req, main_oscillator_dis, internal_oscillator_dis, pdn, byp, use_div, acg;
wire [2:0] src;
wire [8:0] mult;
wire [4:0] div;
wire [5:0] sdiv;
integer error_cnt = 0, tests_run = 0, k;
reg [31:0] seed = 32'hC350, rcc_m = 32'h07803AD1, got, d;
osc_pll_config i_osc_pll_config (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
	.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
	.i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
	.o_main_osc_disable(main_oscillator_dis), .o_internal_osc_disable(internal_oscillator_dis), .o_osc_source(src),
	.o_pll_power_down(pdn), .o_pll_bypass(byp), .o_pll_mult(mult), .o_pll_div(div),
	.o_sys_div(sdiv), .o_use_sys_div(use_div), .o_auto_clock_gate(acg));
initial
	forever #5 i_core_clk = ~i_core_clk;
function [31:0] xs(input [31:0] s);
	reg [31:0] t;
begin
	t = s ^ (s << 13);
	t = t ^ (t >> 17);
	xs = t ^ (t << 5);
end
endfunction
// Expected multiplier and divider per crystal code
function [13:0] xlate(input [3:0] c);
	case (c)
	4'h4: xlate = {9'h1BF, 5'h03};
	4'h5: xlate = {9'h0D9, 5'h01};
	4'h6: xlate = {9'h064, 5'h00};
	4'h7: xlate = {9'h125, 5'h02};
	4'h8: xlate = {9'h197, 5'h04};
	4'h9: xlate = {9'h050, 5'h00};
	4'hA: xlate = {9'h139, 5'h03};
	4'hB: xlate = {9'h0C8, 5'h02};
	4'hC: xlate = {9'h187, 5'h05};
	4'hD: xlate = {9'h0D9, 5'h03};
	4'hE: xlate = {9'h032, 5'h00};
	4'hF: xlate = {9'h125, 5'h05};
	default: xlate = 14'h0;
	endcase
endfunction
function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] b);
	reg [31:0] m;
begin
	m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h0FC02BF3;
	merge = (o & ~m) | (n & m);
end
endfunction
task stop_test;
begin
	$display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
	if (error_cnt == 0 && tests_run > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
end
endtask
task bus(input r, input [7:0] a, input [31:0] dv, input [3:0] b);
	integer n;
begin
	@(posedge i_core_clk);
	rd <= r;
	wr <= !r;
	addr <= a;
	wdata <= dv;
	be <= b;
	n = 0;
	@(posedge i_core_clk);
	while (wait_req !== 1'b0 && n < 20)
	begin
		@(posedge i_core_clk);
		n = n + 1;
	end
	if (wait_req !== 1'b0)
	begin
		error_cnt++;
		$display("ERROR %0t: bus timeout", $time);
		stop_test;
	end
	got = rdata;
	rd <= 1'b0;
	wr <= 1'b0;
end
endtask
task check_ctrl;
begin
	repeat (2) @(posedge i_core_clk);
	#1;
	`CHK(pdn, rcc_m[13])
	`CHK(byp, rcc_m[11])
	`CHK(src, {1'b0, rcc_m[5:4]})
	`CHK(internal_oscillator_dis, rcc_m[1])
	`CHK(main_oscillator_dis, rcc_m[0])
	`CHK({mult, div}, xlate(rcc_m[9:6]))
	`CHK({acg, use_div, sdiv}, {rcc_m[27], rcc_m[22] | ~rcc_m[11], 2'h0, rcc_m[26:23]})
	bus(1, 8'h60, 32'h0, 4'hF);
	`CHK(got, rcc_m)
	bus(1, 8'h64, 32'h0, 4'hF);
	`CHK(got, {18'h0, xlate(rcc_m[9:6])})
end
endtask
initial
begin
	repeat (3) @(posedge i_core_clk);
	i_resetn <= 1'b1;
	bus(1, 8'h70, 32'h0, 4'hF);
	`CHK(got, 32'h07802810)
	check_ctrl;
	$display("Test reset values done");
	for (k = 0; k < 40; k = k + 1)
	begin
		seed = xs(seed);
		d = seed;
		if (k < 16)
			d[9:6] = k[3:0];
		bus(0, 8'h60, d, k < 16 ? 4'hF : seed[19:16]);
		rcc_m = merge(rcc_m, d, k < 16 ? 4'hF : seed[19:16]);
		check_ctrl;
		if (k == 6)
			`CHK(4 * mult / (div + 1), 32'h190)
	end
	$display("Test codes and random writes done");
	bus(0, 8'h64, 32'hFFFFFFFF, 4'hF);
	bus(0, 8'h10, 32'hFFFFFFFF, 4'hF);
	bus(1, 8'h10, 32'h0, 4'hF);
	`CHK(got, 32'h0)
	check_ctrl;
	$display("Test refused writes done");
	bus(0, 8'h70, 32'h80000040, 4'hF);
	repeat (2) @(posedge i_core_clk);
	#1;
	`CHK({pdn, byp, src}, 5'h04)
	`CHK(sdiv, 6'h00)
	bus(0, 8'h70, 32'h07802810, 4'hF);
	check_ctrl;
	$display("Test override done");
	@(posedge i_core_clk);
	i_resetn <= 1'b0;
	repeat (2) @(posedge i_core_clk);
	i_resetn <= 1'b1;
	rcc_m = 32'h07803AD1;
	check_ctrl;
	$display("Test second reset done");
	stop_test;
end
endmodule // osc_pll_config_test
